// File: hw/asf_pkg.sv
// Purpose: shared constants and types for the alu condition flag register
// Assumes: apb slave, 32-bit data, flag word plus read-only info word
// Notes: arithmetic flags reset to zero though they may be taken as unknown
package asf_pkg;
  localparam logic [11:0] ASF_FLAGS_OFFSET = 12'h000;
  localparam logic [11:0] ASF_INFO_OFFSET = 12'h004;
  localparam int ASF_BIT_CARRY = 0;
  localparam int ASF_BIT_HALF = 1;
  localparam int ASF_BIT_ZERO = 2;
  localparam int ASF_BIT_OVF = 3;
  localparam int ASF_BIT_PDOWN = 4;
  localparam int ASF_BIT_WDEXP = 5;
  localparam int ASF_BIT_CZERO = 6;
  localparam int ASF_BIT_SCMP = 7;
  localparam logic [7:0] ASF_FLAGS_RESET = 8'h00;
  localparam logic [7:0] ASF_SW_MASK = 8'hCF;
  localparam logic [7:0] ASF_INFO_ID = 8'h5A; // arbitrary value

  // kind of alu operation being retired
  typedef enum logic [2:0] {
    ASF_OP_NONE = 3'h0,
    ASF_OP_ADD = 3'h1,
    ASF_OP_SUB = 3'h2,
    ASF_OP_LOGIC = 3'h3,
    ASF_OP_ROT = 3'h4
  } asf_op_e;

  // how compare zero is formed for this instruction
  typedef enum logic [1:0] {
    ASF_CZ_KEEP = 2'h0,
    ASF_CZ_ZERO = 2'h1,
    ASF_CZ_CHAIN = 2'h2
  } asf_cz_e;

  typedef struct packed {
    asf_op_e op;
    asf_cz_e cz_mode;
    logic [7:0] a;
    logic [7:0] b;
    logic carry_in;
    logic [7:0] rot_result;
    logic rot_carry;
  } asf_alu_req_s;

  typedef struct packed {
    logic halt;
    logic wdt_clear;
    logic wdt_timeout;
  } asf_sys_ev_s;
endpackage : asf_pkg

// File: hw/asf_alu_eval.sv
// Purpose: combinational flag evaluation for one alu operation
// Assumes: subtraction is a + ~b + carry_in
// Notes: outputs only meaningful when op is not none
`timescale 1ns/1ps
`default_nettype none
module asf_alu_eval
  import asf_pkg::*;
(
  input wire asf_alu_req_s i_req, // operation and operands
  input wire logic i_prev_zero_flag, // compare zero before op
  output logic [7:0] o_result, // operation result
  output logic [7:0] o_flags // computed flag byte
);
  logic [7:0] b_eff;
  logic [4:0] low_sum;
  logic [7:0] low7_sum;
  logic [8:0] full_sum;
  logic carry_into_msb;
  logic carry_out;
  logic ovf;

  always_comb begin
    b_eff = (i_req.op == ASF_OP_SUB) ? ~i_req.b : i_req.b;
    low_sum = {1'b0, i_req.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, i_req.carry_in};
    low7_sum = {1'b0, i_req.a[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, i_req.carry_in};
    full_sum = {1'b0, i_req.a} + {1'b0, b_eff} + {8'h00, i_req.carry_in};
    carry_into_msb = low7_sum[7];
    carry_out = full_sum[8];
    ovf = carry_into_msb ^ carry_out;
    o_result = 8'h00;
    o_flags = 8'h00;
    unique case (i_req.op)
      ASF_OP_ADD, ASF_OP_SUB: begin
        o_result = full_sum[7:0];
        o_flags[ASF_BIT_CARRY] = carry_out;
        o_flags[ASF_BIT_HALF] = low_sum[4];
        o_flags[ASF_BIT_OVF] = ovf;
      end
      ASF_OP_LOGIC: begin
        o_result = i_req.a;
      end
      ASF_OP_ROT: begin
        o_result = i_req.rot_result;
        o_flags[ASF_BIT_CARRY] = i_req.rot_carry;
      end
      ASF_OP_NONE: begin
        o_result = 8'h00;
      end
      default: begin
        o_result = 8'h00;
      end
    endcase
    o_flags[ASF_BIT_ZERO] = (o_result == 8'h00);
    o_flags[ASF_BIT_SCMP] = o_flags[ASF_BIT_OVF] ^ o_result[7];
    // chained compares keep zero only if the earlier part was zero too
    o_flags[ASF_BIT_CZERO] = (i_req.cz_mode == ASF_CZ_CHAIN) ?
        (o_flags[ASF_BIT_ZERO] & i_prev_zero_flag) : o_flags[ASF_BIT_ZERO];
  end
endmodule : asf_alu_eval
`default_nettype wire

// File: hw/asf_sys_flags.sv
// Purpose: watchdog expired and power down flag pair
// Assumes: events are one-cycle pulses from the core
// Notes: no path from software writes reaches these flops
`timescale 1ns/1ps
`default_nettype none
module asf_sys_flags
  import asf_pkg::*;
(
  input wire logic i_clock, // core clock
  input wire logic i_reset_n, // async power-on reset
  input wire asf_sys_ev_s i_ev, // halt, wdt clear, timeout
  output logic o_wdexp, // watchdog expired flag
  output logic o_pdown // power down flag
);
  logic wdexp;
  logic pdown;
  logic next_wdexp;
  logic next_pdown;

  always_comb begin
    next_wdexp = wdexp;
    next_pdown = pdown;
    if (i_ev.wdt_clear || i_ev.halt) begin
      next_wdexp = 1'b0;
    end
    // a timeout in the clearing cycle is not lost
    if (i_ev.wdt_timeout) begin
      next_wdexp = 1'b1;
    end
    if (i_ev.wdt_clear) begin
      next_pdown = 1'b0;
    end
    if (i_ev.halt) begin
      next_pdown = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wdexp <= 1'b0;
      pdown <= 1'b0;
    end else begin
      wdexp <= next_wdexp;
      pdown <= next_pdown;
    end
  end

  assign o_wdexp = wdexp;
  assign o_pdown = pdown;

  chk_halt_sets_pd: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_ev.halt |=> pdown) else $error("halt did not set power down");
  chk_clear_drops_pd: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_ev.wdt_clear && !i_ev.halt) |=> !pdown) else $error("wdt clear left power down");
  chk_timeout_sets_to: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_ev.wdt_timeout |=> wdexp) else $error("timeout lost");
  chk_halt_clears_to: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_ev.halt && !i_ev.wdt_timeout) |=> !wdexp) else $error("halt left expired flag");
endmodule : asf_sys_flags
`default_nettype wire

// File: hw/asf_status_reg.sv
// Purpose: alu condition flag register with apb access
// Assumes: apb3 slave, zero wait states, word-aligned byte addresses
// Notes: alu update wins over a same-cycle software write
`timescale 1ns/1ps
`default_nettype none
module asf_status_reg
  import asf_pkg::*;
(
  input wire logic i_clock, // core clock 100 MHz
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [11:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  input wire logic [3:0] i_pstrb, // apb byte strobes
  input wire logic i_alu_valid, // alu op retires this cycle
  input wire asf_alu_req_s i_alu_req, // alu op and operands
  input wire asf_sys_ev_s i_sys_ev, // system events
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error
  output logic [31:0] o_prdata, // apb read data
  output logic [7:0] o_flags, // flag byte to core, expired and power down bits always zero
  output logic [7:0] o_alu_result // registered alu result
);
  logic [5:0] arith;
  logic [5:0] next_arith;
  logic [7:0] alu_result;
  logic [7:0] next_alu_result;
  logic [7:0] eval_result;
  logic [7:0] eval_flags;
  logic wdexp;
  logic pdown;
  logic [7:0] flag_view;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic setup;
  logic wr_flags;

  function automatic logic [7:0] pack_flags(input logic [5:0] ar, input logic to, input logic pd);
    logic [7:0] f;
    f = 8'h00;
    f[ASF_BIT_CARRY] = ar[0];
    f[ASF_BIT_HALF] = ar[1];
    f[ASF_BIT_ZERO] = ar[2];
    f[ASF_BIT_OVF] = ar[3];
    f[ASF_BIT_CZERO] = ar[4];
    f[ASF_BIT_SCMP] = ar[5];
    f[ASF_BIT_WDEXP] = to;
    f[ASF_BIT_PDOWN] = pd;
    return f;
  endfunction : pack_flags

  function automatic logic [5:0] unpack_arith(input logic [7:0] f);
    return {f[ASF_BIT_SCMP], f[ASF_BIT_CZERO], f[ASF_BIT_OVF],
            f[ASF_BIT_ZERO], f[ASF_BIT_HALF], f[ASF_BIT_CARRY]};
  endfunction : unpack_arith

  asf_alu_eval u_eval (
    .i_req(i_alu_req),
    .i_prev_zero_flag(arith[4]),
    .o_result(eval_result),
    .o_flags(eval_flags)
  );

  asf_sys_flags u_sys (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_ev(i_sys_ev),
    .o_wdexp(wdexp),
    .o_pdown(pdown)
  );

  assign flag_view = pack_flags(arith, wdexp, pdown);
  // setup phase decode; answer given in access phase of the next cycle
  assign setup = i_psel && !i_penable;
  assign wr_flags = i_psel && i_penable && pready && i_pwrite &&
                    (i_paddr == ASF_FLAGS_OFFSET) && i_pstrb[0];

  always_comb begin
    next_arith = arith;
    next_alu_result = alu_result;
    if (wr_flags) begin
      // only the writable bits; expired and power down are elsewhere
      next_arith = unpack_arith(i_pwdata[7:0] & ASF_SW_MASK);
    end
    if (i_alu_valid && i_alu_req.op != ASF_OP_NONE) begin
      next_alu_result = eval_result;
      unique case (i_alu_req.op)
        ASF_OP_ADD, ASF_OP_SUB: begin
          // compare zero is left to the cz_mode decode below
          next_arith[0] = eval_flags[ASF_BIT_CARRY];
          next_arith[1] = eval_flags[ASF_BIT_HALF];
          next_arith[2] = eval_flags[ASF_BIT_ZERO];
          next_arith[3] = eval_flags[ASF_BIT_OVF];
          next_arith[5] = eval_flags[ASF_BIT_SCMP];
        end
        ASF_OP_LOGIC: begin
          next_arith[2] = eval_flags[ASF_BIT_ZERO];
          next_arith[3] = 1'b0;
          next_arith[5] = eval_flags[ASF_BIT_SCMP];
        end
        ASF_OP_ROT: begin
          next_arith[0] = eval_flags[ASF_BIT_CARRY];
        end
        default: begin
          next_arith = next_arith;
        end
      endcase
      if (i_alu_req.cz_mode != ASF_CZ_KEEP && i_alu_req.op != ASF_OP_ROT) begin
        next_arith[4] = eval_flags[ASF_BIT_CZERO];
      end
    end
  end

  always_comb begin
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (setup) begin
      next_pready = 1'b1;
      next_prdata = 32'h0000_0000;
      if (i_paddr == ASF_FLAGS_OFFSET) begin
        next_prdata = {24'h00_0000, flag_view};
      end else if (i_paddr == ASF_INFO_OFFSET) begin
        next_prdata = {24'h00_0000, ASF_INFO_ID};
        next_pslverr = i_pwrite;
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      arith <= ASF_FLAGS_RESET[5:0];
      alu_result <= 8'h00;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      o_flags <= ASF_FLAGS_RESET;
    end else begin
      arith <= next_arith;
      alu_result <= next_alu_result;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
      o_flags <= pack_flags(next_arith, 1'b0, 1'b0) | 8'h00;
    end
  end

  assign o_pready = pready;
  assign o_pslverr = pslverr;
  assign o_prdata = prdata;
  assign o_alu_result = alu_result;

  sequence s_sw_write;
    wr_flags && !i_alu_valid;
  endsequence

  chk_write_keeps_sys: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (s_sw_write and (!i_sys_ev.halt && !i_sys_ev.wdt_clear && !i_sys_ev.wdt_timeout))
      |=> ($stable(wdexp) && $stable(pdown))) else $error("write touched system flags");
  chk_add_carry: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_alu_valid && i_alu_req.op == ASF_OP_ADD)
      |=> arith[0] == ($past({1'b0, i_alu_req.a} + {1'b0, i_alu_req.b}
          + {8'h00, i_alu_req.carry_in}) > 9'h0FF)) else $error("add carry wrong");
  chk_sub_carry: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_alu_valid && i_alu_req.op == ASF_OP_SUB && i_alu_req.carry_in)
      |=> arith[0] == $past(i_alu_req.a >= i_alu_req.b)) else $error("sub carry wrong");
  chk_zero_flag: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_alu_valid && i_alu_req.op != ASF_OP_NONE && i_alu_req.op != ASF_OP_ROT)
      |=> arith[2] == (alu_result == 8'h00)) else $error("zero flag wrong");
  chk_signed_cmp: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_alu_valid && (i_alu_req.op == ASF_OP_ADD || i_alu_req.op == ASF_OP_SUB))
      |=> arith[5] == (arith[3] ^ alu_result[7])) else $error("signed compare wrong");
  chk_rot_carry: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_alu_valid && i_alu_req.op == ASF_OP_ROT)
      |=> arith[0] == $past(i_alu_req.rot_carry)) else $error("rotate carry wrong");
  chk_ovf_flag: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_alu_valid && (i_alu_req.op == ASF_OP_ADD || i_alu_req.op == ASF_OP_SUB))
      |=> arith[3] == $past((i_alu_req.a[7] == (i_alu_req.b[7] ^ (i_alu_req.op == ASF_OP_SUB)))
          && (eval_result[7] != i_alu_req.a[7]))) else $error("overflow flag wrong");
  chk_cz_keep: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_alu_valid && (i_alu_req.cz_mode == ASF_CZ_KEEP || i_alu_req.op == ASF_OP_ROT) && !wr_flags)
      |=> $stable(arith[4])) else $error("compare zero not kept");
  chk_apb_answer: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    setup |=> pready ##1 !pready) else $error("apb answer timing");
endmodule : asf_status_reg
`default_nettype wire

// File: verification/asf_status_reg_tb.sv
// Purpose: self-checking bench for the alu condition flag register
// Assumes: zero wait apb slave, flags update on the retire edge
// Notes: expected flags come from a small model kept here
`timescale 1ns/1ps
`default_nettype none
module asf_status_reg_tb
  import asf_pkg::*;
;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic alu_valid = 1'b0;
  asf_alu_req_s alu_req = '0;
  asf_sys_ev_s sys_ev = '0;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic [7:0] flags;
  logic [7:0] alu_res;
  int error_cnt = 0;
  int num_checks = 0;
  logic [7:0] e_ar = 8'h00;
  logic e_wd = 1'b0;
  logic e_pd = 1'b0;

  always #5 clock = ~clock;

  asf_status_reg i_dut (.i_clock(clock), .i_reset_n(reset_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .i_alu_valid(alu_valid),
    .i_alu_req(alu_req), .i_sys_ev(sys_ev), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .o_flags(flags), .o_alu_result(alu_res));

  task automatic end_sim();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    e_ar = 8'h00;
    e_wd = 1'b0;
    e_pd = 1'b0;
  endtask : do_reset

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // read before this edge's updates land: the value the slave showed
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        error_cnt++;
        end_sim();
      end
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk();
    logic [31:0] rd;
    logic err;
    apb(1'b0, ASF_FLAGS_OFFSET, 32'h0, rd, err);
    chk("flags_word", {24'h0, e_ar[7:6], e_wd, e_pd, e_ar[3:0]}, rd);
    chk("flags_err", 32'h0, {31'h0, err});
  endtask : rd_chk

  task automatic wr_flags(input logic [7:0] v);
    logic [31:0] rd;
    logic err;
    apb(1'b1, ASF_FLAGS_OFFSET, {24'h0, v}, rd, err);
    e_ar = v & ASF_SW_MASK;
    chk("write_err", 32'h0, {31'h0, err});
  endtask : wr_flags

  task automatic ev(input logic h, input logic c, input logic t);
    @(posedge clock);
    sys_ev <= '{halt: h, wdt_clear: c, wdt_timeout: t};
    @(posedge clock);
    sys_ev <= '0;
  endtask : ev

  task automatic alu(input asf_op_e op, input asf_cz_e cz, input logic [7:0] a, input logic [7:0] b,
                     input logic cin, input logic [7:0] rr, input logic rc);
    logic [7:0] bb;
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] c7;
    logic [7:0] res;
    logic ov;
    logic z;
    bb = (op == ASF_OP_SUB) ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h0, cin};
    h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
    c7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h0, cin};
    res = (op == ASF_OP_ROT) ? rr : ((op == ASF_OP_LOGIC) ? a : s[7:0]);
    z = (res == 8'h00);
    if (op == ASF_OP_ROT) begin
      e_ar[0] = rc;
    end else begin
      if (op != ASF_OP_LOGIC) begin
        e_ar[0] = s[8];
        e_ar[1] = h[4];
      end
      ov = (op == ASF_OP_LOGIC) ? 1'b0 : (c7[7] ^ s[8]);
      e_ar[3] = ov;
      e_ar[2] = z;
      e_ar[7] = ov ^ res[7];
      if (cz == ASF_CZ_ZERO) e_ar[6] = z;
      if (cz == ASF_CZ_CHAIN) e_ar[6] = z & e_ar[6];
    end
    @(posedge clock);
    alu_valid <= 1'b1;
    alu_req <= '{op: op, cz_mode: cz, a: a, b: b, carry_in: cin, rot_result: rr, rot_carry: rc};
    @(posedge clock);
    alu_valid <= 1'b0;
    #1;
    chk("alu_flags", {24'h0, e_ar}, {24'h0, flags});
    chk("alu_result", {24'h0, res}, {24'h0, alu_res});
  endtask : alu

  task automatic t_reset_vals();
    logic [31:0] rd;
    logic err;
    rd_chk();
    chk("out_flags", 32'h0, {24'h0, flags});
    apb(1'b0, ASF_INFO_OFFSET, 32'h0, rd, err);
    chk("info_word", {24'h0, ASF_INFO_ID}, rd);
    chk("info_err", 32'h0, {31'h0, err});
    apb(1'b0, 12'h008, 32'h0, rd, err);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    apb(1'b1, ASF_INFO_OFFSET, 32'hFF, rd, err);
    chk("ro_write_err", 32'h1, {31'h0, err});
  endtask : t_reset_vals

  task automatic t_arith();
    alu(ASF_OP_ADD, ASF_CZ_ZERO, 8'hFF, 8'h01, 1'b0, 8'h00, 1'b0);
    alu(ASF_OP_ADD, ASF_CZ_ZERO, 8'h80, 8'h80, 1'b0, 8'h00, 1'b0);
    alu(ASF_OP_ADD, ASF_CZ_ZERO, 8'h7F, 8'h01, 1'b0, 8'h00, 1'b0);
    alu(ASF_OP_ADD, ASF_CZ_ZERO, 8'h0F, 8'h00, 1'b1, 8'h00, 1'b0);
    alu(ASF_OP_SUB, ASF_CZ_ZERO, 8'h05, 8'h05, 1'b1, 8'h00, 1'b0);
    alu(ASF_OP_SUB, ASF_CZ_ZERO, 8'h00, 8'h01, 1'b1, 8'h00, 1'b0);
    alu(ASF_OP_SUB, ASF_CZ_ZERO, 8'h80, 8'h01, 1'b1, 8'h00, 1'b0);
    alu(ASF_OP_SUB, ASF_CZ_ZERO, 8'h10, 8'h01, 1'b1, 8'h00, 1'b0);
    alu(ASF_OP_SUB, ASF_CZ_ZERO, 8'h05, 8'h03, 1'b0, 8'h00, 1'b0);
    alu(ASF_OP_SUB, ASF_CZ_ZERO, 8'h03, 8'h03, 1'b0, 8'h00, 1'b0);
    alu(ASF_OP_ADD, ASF_CZ_CHAIN, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0);
    alu(ASF_OP_ADD, ASF_CZ_CHAIN, 8'h01, 8'h00, 1'b0, 8'h00, 1'b0);
    alu(ASF_OP_ADD, ASF_CZ_KEEP, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0);
    alu(ASF_OP_LOGIC, ASF_CZ_ZERO, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0);
    alu(ASF_OP_LOGIC, ASF_CZ_KEEP, 8'h80, 8'h00, 1'b0, 8'h00, 1'b0);
    alu(ASF_OP_ROT, ASF_CZ_KEEP, 8'h00, 8'h00, 1'b0, 8'h55, 1'b1);
    alu(ASF_OP_ROT, ASF_CZ_ZERO, 8'h00, 8'h00, 1'b0, 8'hAA, 1'b0);
  endtask : t_arith

  task automatic t_sys();
    logic [31:0] rd;
    logic err;
    ev(1'b0, 1'b0, 1'b1);
    e_wd = 1'b1;
    rd_chk();
    wr_flags(8'h00);
    rd_chk();
    ev(1'b1, 1'b0, 1'b0);
    e_pd = 1'b1;
    e_wd = 1'b0;
    rd_chk();
    wr_flags(8'hFF);
    rd_chk();
    chk("out_flags", {24'h0, e_ar}, {24'h0, flags});
    // write without strobe 0 must leave the register alone
    @(posedge clock);
    pstrb <= 4'hE;
    apb(1'b1, ASF_FLAGS_OFFSET, 32'h0, rd, err);
    pstrb <= 4'hF;
    rd_chk();
    ev(1'b0, 1'b0, 1'b1);
    ev(1'b0, 1'b1, 1'b0);
    e_wd = 1'b0;
    e_pd = 1'b0;
    rd_chk();
    ev(1'b0, 1'b1, 1'b1);
    e_wd = 1'b1;
    rd_chk();
    ev(1'b1, 1'b1, 1'b0);
    e_wd = 1'b0;
    e_pd = 1'b1;
    rd_chk();
    ev(1'b0, 1'b0, 1'b1);
    ev(1'b1, 1'b0, 1'b0);
    do_reset();
    rd_chk();
  endtask : t_sys

  initial begin
    do_reset();
    t_reset_vals();
    t_arith();
    t_sys();
    end_sim();
  end
endmodule : asf_status_reg_tb
`default_nettype wire
